// ---- hw/irs_dev_end.sv ----
// Purpose: slave end of the two-wire register port with coefficient store
// Assumes: link clock and pins are sampled by hclk through irs_sync
// Notes: address pin and strap are caught once after reset release
// How it works
// [RL1] Slave only; bit timing from host clock
// [RL2] Data line only pulled low or released
// [RL3] Data change with clock high is start/stop
// [RL4] Stop returns control state to idle
// [RL5] Bytes MSB first, slot nine is acknowledge
// [RL6] Acknowledge every byte received in writes
// [RL7] Last address bit selects write or read
// [RL8] Second byte index, third byte data
// [RL9] Without step flag, index/data pairs repeat
// [RL10] Index MSB is step flag; increments index
// [RL11] Stepping skips 0x3B-0x49, 0x4F, 0x5E
// [RL12] Coefficient mode: four bytes, MSB first
// [RL13] Access-select picks byte or bank words
// [RL14] Value 0x03 writes both channel banks
// [RL15] Host sets access-select before bank access
// [RL16] Filter indices grouped in sets of five
// [RL17] Shadow set committed on fifth coefficient
// [RL18] Read: write index, repeated start, read
// [RL19] Slot nine sampled in reads for host ack
// [RL20] Host not-acknowledge ends read data
// [RL21] Read with step flag walks upward
// [RL22] Address pin low: 0x54 or 0x58
// [RL23] Address pin high: 0x56 or 0x5A
module irs_dev_end
   import irs_pkg::*;
(
   input wire logic hclk,
   input wire logic hresetn,
   irs_link_if.dev link,
   input wire logic ad_pin,
   input wire logic strap_pin,
   output logic [7:0] access_select,
   output logic coef_commit,
   output logic busy
);
   typedef struct packed {
      logic scl_p;
      logic sda_p;
      irs_dev_phase_type phase;
      irs_role_type role;
      logic [3:0] bits;
      logic [7:0] sh;
      logic rw;
      logic index_step_flag;
      logic drive;
      logic [2:0] ok;
      logic [7:0] dev_addr;
      logic [6:0] idx;
      logic [1:0] wcnt;
      logic [23:0] acc;
      logic commit;
      logic busy;
      logic [127:0][7:0] regs;
      logic [4:0][31:0] shadow;
      logic [2:0][107:0][31:0] mem;
   } irs_dev_state_type;

   irs_dev_state_type s_q, s_d;
   logic [3:0] pins;
   logic scl;
   logic sda;
   logic ad;
   logic strap;

   irs_sync #(.W(4)) u_sync (
      .hclk(hclk),
      .hresetn(hresetn),
      .din({link.scl, link.sda, ad_pin, strap_pin}),
      .dout(pins)
   );
   assign {scl, sda, ad, strap} = pins;

   function automatic logic [6:0] irs_next_idx(logic [6:0] i);
      logic [6:0] n;
      n = 7'(i + 7'h01);
      if (n >= IRS_SKIP_LO && n <= IRS_SKIP_HI) begin
         n = 7'(IRS_SKIP_HI + 7'h01); // RL11
      end
      if (n == IRS_SKIP_A || n == IRS_SKIP_B) begin
         n = 7'(n + 7'h01); // RL11
      end
      return n;
   endfunction

   function automatic logic irs_coef_mode(irs_dev_state_type s);
      return (s.regs[IRS_SEL_IDX] != IRS_SEL_BYTE) && (s.idx <= IRS_COEF_LAST); // RL13
   endfunction

   function automatic logic [7:0] irs_tx_byte(irs_dev_state_type s);
      logic [31:0] w;
      logic [7:0] sel;
      sel = s.regs[IRS_SEL_IDX];
      w = sel[0] ? s.mem[0][s.idx] : (sel[1] ? s.mem[1][s.idx] : s.mem[2][s.idx]);
      if (irs_coef_mode(s)) begin
         return w[8 * (3 - int'(s.wcnt)) +: 8]; // RL12
      end
      return s.regs[s.idx];
   endfunction

   always_comb begin
      logic [31:0] w;
      logic [6:0] pos;
      logic [6:0] base;
      logic [2:0] banks;
      logic start;
      logic stop;
      logic rise;
      logic fall;
      w = {s_q.acc, s_q.sh};
      pos = 7'(s_q.idx % IRS_BQ_SET);
      base = 7'(s_q.idx - pos);
      banks = {s_q.regs[IRS_SEL_IDX][3], s_q.regs[IRS_SEL_IDX][1], s_q.regs[IRS_SEL_IDX][0]};
      start = s_q.scl_p & scl & s_q.sda_p & ~sda; // RL3
      stop = s_q.scl_p & scl & ~s_q.sda_p & sda; // RL3
      rise = scl & ~s_q.scl_p; // RL1
      fall = ~scl & s_q.scl_p; // RL1
      s_d = s_q;
      s_d.scl_p = scl;
      s_d.sda_p = sda;
      s_d.commit = 1'b0;
      s_d.ok = {s_q.ok[1:0], 1'b1};
      if (s_q.ok == 3'h3) begin
         s_d.dev_addr = ad ? (strap ? IRS_ADDR_H_H : IRS_ADDR_H_L) // RL23
                           : (strap ? IRS_ADDR_L_H : IRS_ADDR_L_L); // RL22
      end
      if (stop) begin
         s_d.phase = DP_IDLE; // RL4
         s_d.drive = 1'b0;
      end else if (start) begin
         s_d.phase = DP_RX;
         s_d.role = RO_ADDR;
         s_d.bits = 4'h0;
         s_d.wcnt = 2'h0;
         s_d.drive = 1'b0;
      end else begin
         case (s_q.phase)
            DP_RX: begin
               if (rise) begin
                  s_d.sh = {s_q.sh[6:0], sda}; // RL5
                  s_d.bits = 4'(s_q.bits + 4'h1);
               end else if (fall && s_q.bits == IRS_BITS_BYTE) begin
                  s_d.bits = 4'h0;
                  s_d.phase = DP_ACK;
                  s_d.drive = 1'b1; // RL6
                  case (s_q.role)
                     RO_ADDR: begin
                        s_d.rw = s_q.sh[0]; // RL7
                        s_d.role = s_q.sh[0] ? RO_ADDR : RO_INDEX;
                        if (s_q.sh[7:1] != s_q.dev_addr[7:1]) begin
                           s_d.phase = DP_IDLE;
                           s_d.drive = 1'b0;
                        end
                     end
                     RO_INDEX: begin
                        s_d.index_step_flag = s_q.sh[7]; // RL10
                        s_d.idx = s_q.sh[6:0]; // RL8
                        s_d.wcnt = 2'h0;
                        s_d.role = RO_DATA;
                     end
                     default: begin
                        if (irs_coef_mode(s_q)) begin
                           s_d.acc = w[23:0]; // RL12
                           s_d.wcnt = 2'(s_q.wcnt + 2'h1);
                           if (s_q.wcnt == 2'h3) begin
                              if (s_q.idx <= IRS_BQ0_HI ||
                                  (s_q.idx >= IRS_BQ1_LO && s_q.idx <= IRS_BQ1_HI)) begin
                                 s_d.shadow[pos[2:0]] = w; // RL16
                                 if (pos == 7'h04) begin
                                    s_d.commit = 1'b1; // RL17
                                    for (int j = 0; j < 3; j++) begin
                                       for (int k = 0; k < 5; k++) begin
                                          if (banks[j]) begin
                                             s_d.mem[j][7'(base + 7'(k))] = s_d.shadow[k];
                                          end
                                       end
                                    end
                                 end
                              end else begin
                                 for (int j = 0; j < 3; j++) begin
                                    if (banks[j]) begin
                                       s_d.mem[j][s_q.idx] = w; // RL14
                                    end
                                 end
                              end
                              s_d.idx = s_q.index_step_flag ? irs_next_idx(s_q.idx) : s_q.idx; // RL10
                              s_d.role = s_q.index_step_flag ? RO_DATA : RO_INDEX; // RL9
                           end
                        end else begin
                           s_d.regs[s_q.idx] = s_q.sh; // RL8
                           s_d.idx = s_q.index_step_flag ? irs_next_idx(s_q.idx) : s_q.idx; // RL10
                           s_d.role = s_q.index_step_flag ? RO_DATA : RO_INDEX; // RL9
                        end
                     end
                  endcase
               end
            end
            DP_ACK: begin
               if (fall) begin
                  s_d.drive = 1'b0; // RL2
                  s_d.phase = DP_RX;
                  if (s_q.role == RO_ADDR && s_q.rw) begin
                     s_d.phase = DP_TX; // RL18
                     s_d.sh = irs_tx_byte(s_q);
                     s_d.drive = ~s_d.sh[7]; // RL2
                     s_d.bits = 4'h0;
                  end
               end
            end
            DP_TX: begin
               if (fall) begin
                  s_d.bits = 4'(s_q.bits + 4'h1);
                  s_d.sh = {s_q.sh[6:0], 1'b0};
                  s_d.drive = ~s_d.sh[7]; // RL5
                  if (s_q.bits == 4'h7) begin
                     s_d.drive = 1'b0;
                     s_d.phase = DP_HACK;
                  end
               end
            end
            DP_HACK: begin
               if (rise && sda) begin
                  s_d.phase = DP_IDLE; // RL20
               end else if (fall) begin
                  s_d.wcnt = irs_coef_mode(s_q) ? 2'(s_q.wcnt + 2'h1) : 2'h0; // RL19
                  if (s_q.index_step_flag && (!irs_coef_mode(s_q) || s_q.wcnt == 2'h3)) begin
                     s_d.idx = irs_next_idx(s_q.idx); // RL21
                  end
                  s_d.sh = irs_tx_byte(s_d);
                  s_d.drive = ~s_d.sh[7];
                  s_d.bits = 4'h0;
                  s_d.phase = DP_TX;
               end
            end
            default: begin
               s_d.drive = 1'b0;
            end
         endcase
      end
      s_d.busy = (s_d.phase != DP_IDLE);
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign link.dev_sda_o = 1'b0; // RL2
   assign link.dev_sda_oe_n = ~s_q.drive;
   assign access_select = s_q.regs[IRS_SEL_IDX];
   assign coef_commit = s_q.commit;
   assign busy = s_q.busy;
endmodule

// ---- hw/irs_host_end.sv ----
// Purpose: two-wire bus master driven from AHB-Lite registers
// Assumes: one slave on the bus, zero wait states, response always OKAY
// Notes: a command moves at most one byte; the clock line is held between commands
module irs_host_end
   import irs_pkg::*;
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic [31:0] hrdata,
   output logic hresp,
   irs_link_if.host link
);
   typedef struct packed {
      logic wpend;
      logic [7:0] waddr;
      logic [31:0] rdata;
      irs_host_phase_type st;
      logic [1:0] step;
      logic [3:0] bitn;
      logic [7:0] cnt;
      logic [7:0] div;
      logic [7:0] tx;
      logic [7:0] rx;
      logic do_stop;
      logic rd;
      logic nak;
      logic nobyte;
      logic ack;
      logic scl;
      logic drive;
      logic busy;
   } irs_host_state_type;

   irs_host_state_type s_q, s_d;
   logic sda;

   irs_sync #(.W(1)) u_sync (
      .hclk(hclk),
      .hresetn(hresetn),
      .din(link.sda),
      .dout(sda)
   );

   always_comb begin
      logic tick;
      tick = (s_q.cnt >= s_q.div);
      s_d = s_q;
      s_d.cnt = tick ? 8'h00 : 8'(s_q.cnt + 8'h01);
      if (hsel && htrans[1] && hready) begin
         s_d.wpend = hwrite & (hsize == 3'h2);
         s_d.waddr = haddr[7:0];
         case (haddr[7:0])
            IRS_STAT_OFS: s_d.rdata = {16'h0000, s_q.rx, 6'h00, s_q.ack, s_q.busy};
            IRS_DIV_OFS: s_d.rdata = {24'h000000, s_q.div};
            default: s_d.rdata = 32'h00000000;
         endcase
      end else begin
         s_d.wpend = 1'b0;
      end
      if (s_q.wpend && s_q.waddr == IRS_DIV_OFS) begin
         s_d.div = (hwdata[7:0] == 8'h00) ? 8'h01 : hwdata[7:0];
      end
      if (s_q.wpend && s_q.waddr == IRS_CMD_OFS && !s_q.busy) begin
         s_d.busy = 1'b1;
         s_d.tx = hwdata[IRS_CMD_TX_LSB +: 8];
         s_d.do_stop = hwdata[IRS_CMD_STOP];
         s_d.rd = hwdata[IRS_CMD_READ];
         s_d.nak = hwdata[IRS_CMD_NAK];
         s_d.nobyte = hwdata[IRS_CMD_NOBYTE];
         s_d.step = 2'h0;
         s_d.bitn = 4'h0;
         s_d.cnt = 8'h00;
         s_d.st = hwdata[IRS_CMD_START] ? HS_START
                : (hwdata[IRS_CMD_NOBYTE] ? (hwdata[IRS_CMD_STOP] ? HS_STOP : HS_IDLE) : HS_BIT);
         s_d.busy = (s_d.st != HS_IDLE);
      end else if (tick && s_q.st != HS_IDLE) begin
         s_d.step = 2'(s_q.step + 2'h1);
         case (s_q.st)
            HS_START: begin
               case (s_q.step)
                  2'h0: s_d.drive = 1'b0;
                  2'h1: s_d.scl = 1'b1;
                  2'h2: s_d.drive = 1'b1; // RL3
                  default: begin
                     s_d.scl = 1'b0;
                     s_d.st = s_q.nobyte ? (s_q.do_stop ? HS_STOP : HS_IDLE) : HS_BIT;
                  end
               endcase
            end
            HS_BIT: begin
               case (s_q.step)
                  2'h0: begin
                     if (s_q.bitn < IRS_BITS_BYTE) begin
                        s_d.drive = ~s_q.rd & ~s_q.tx[7]; // RL5
                     end else begin
                        s_d.drive = s_q.rd & ~s_q.nak; // RL19
                     end
                  end
                  2'h1: s_d.scl = 1'b1;
                  2'h2: begin
                     if (s_q.bitn < IRS_BITS_BYTE) begin
                        s_d.rx = {s_q.rx[6:0], sda};
                     end else begin
                        s_d.ack = ~sda;
                     end
                  end
                  default: begin
                     s_d.scl = 1'b0;
                     s_d.tx = {s_q.tx[6:0], 1'b0};
                     s_d.bitn = 4'(s_q.bitn + 4'h1);
                     if (s_q.bitn == IRS_BITS_BYTE) begin
                        s_d.st = s_q.do_stop ? HS_STOP : HS_IDLE;
                     end
                  end
               endcase
            end
            default: begin
               case (s_q.step)
                  2'h0: s_d.drive = 1'b1;
                  2'h1: s_d.scl = 1'b1;
                  2'h2: s_d.drive = 1'b0; // RL3
                  default: s_d.st = HS_IDLE;
               endcase
            end
         endcase
         s_d.busy = (s_d.st != HS_IDLE);
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         s_q <= '0;
         s_q.scl <= 1'b1;
         s_q.div <= IRS_DIV_RST;
      end else begin
         s_q <= s_d;
      end
   end

   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign hrdata = s_q.rdata;
   assign link.scl = s_q.scl;
   assign link.host_sda_o = 1'b0; // RL2
   assign link.host_sda_oe_n = ~s_q.drive;
endmodule

// ---- hw/irs_link_if.sv ----
// Purpose: open-drain two-wire link between host end and device end
// Assumes: output enables are low while a party pulls the line
// Notes: the data line is high unless some party drives low
interface irs_link_if;
   logic scl;
   logic host_sda_o;
   logic host_sda_oe_n;
   logic dev_sda_o;
   logic dev_sda_oe_n;
   wire sda = ~((~host_sda_oe_n & ~host_sda_o) | (~dev_sda_oe_n & ~dev_sda_o));
   modport host (output scl, output host_sda_o, output host_sda_oe_n, input sda);
   modport dev (input scl, input sda, output dev_sda_o, output dev_sda_oe_n);
endinterface

// ---- hw/irs_pkg.sv ----
// Purpose: shared constants and types of the two-wire register port
// Assumes: device and host ends both import this package
// Notes: indices are the 7-bit register index carried in the index byte
package irs_pkg;
   // Register index map of the device
   localparam logic [6:0] IRS_SEL_IDX = 7'h7E;
   localparam logic [6:0] IRS_COEF_LAST = 7'h6B;
   localparam logic [6:0] IRS_SKIP_LO = 7'h3B;
   localparam logic [6:0] IRS_SKIP_HI = 7'h49;
   localparam logic [6:0] IRS_SKIP_A = 7'h4F;
   localparam logic [6:0] IRS_SKIP_B = 7'h5E;
   localparam logic [6:0] IRS_BQ0_HI = 7'h09;
   localparam logic [6:0] IRS_BQ1_LO = 7'h14;
   localparam logic [6:0] IRS_BQ1_HI = 7'h3B;
   localparam logic [6:0] IRS_BQ_SET = 7'h05;
   localparam logic [6:0] IRS_COEF_DEPTH = 7'h6C;
   localparam logic [7:0] IRS_SEL_RST = 8'h00;
   // Access-select values
   localparam logic [7:0] IRS_SEL_BYTE = 8'h00;
   localparam logic [7:0] IRS_SEL_CH1 = 8'h01;
   localparam logic [7:0] IRS_SEL_CH2 = 8'h02;
   localparam logic [7:0] IRS_SEL_BOTH = 8'h03;
   localparam logic [7:0] IRS_SEL_EQ = 8'h08;
   // Slave address bytes, direction bit clear
   localparam logic [7:0] IRS_ADDR_L_L = 8'h54;
   localparam logic [7:0] IRS_ADDR_L_H = 8'h58;
   localparam logic [7:0] IRS_ADDR_H_L = 8'h56;
   localparam logic [7:0] IRS_ADDR_H_H = 8'h5A;
   // Host controller registers on AHB-Lite
   localparam logic [7:0] IRS_CMD_OFS = 8'h00;
   localparam logic [7:0] IRS_STAT_OFS = 8'h04;
   localparam logic [7:0] IRS_DIV_OFS = 8'h08;
   localparam logic [7:0] IRS_DIV_RST = 8'h08;
   localparam int IRS_CMD_START = 0;
   localparam int IRS_CMD_STOP = 1;
   localparam int IRS_CMD_READ = 2;
   localparam int IRS_CMD_NAK = 3;
   localparam int IRS_CMD_NOBYTE = 4;
   localparam int IRS_CMD_TX_LSB = 8;
   localparam logic [3:0] IRS_BITS_BYTE = 4'h8;

   typedef enum logic [2:0] {DP_IDLE, DP_RX, DP_ACK, DP_TX, DP_HACK} irs_dev_phase_type;
   typedef enum logic [1:0] {RO_ADDR, RO_INDEX, RO_DATA} irs_role_type;
   typedef enum logic [1:0] {HS_IDLE, HS_START, HS_BIT, HS_STOP} irs_host_phase_type;
endpackage

// ---- hw/irs_sync.sv ----
// Purpose: two-flop synchroniser for pins from outside the clock domain
// Assumes: each bit is an independent level
// Notes: only the second stage is visible
module irs_sync #(
   parameter int W = 1
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic [W-1:0] din,
   output logic [W-1:0] dout
);
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
   } irs_sync_state_type;
   irs_sync_state_type s_q, s_d;

   always_comb begin
      s_d.s1 = din;
      s_d.s2 = s_q.s1;
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign dout = s_q.s2;
endmodule

// ---- testbench/irs_link_properties.sv ----
// Purpose: link protocol properties of the two-wire register port
// Assumes: raw link signals sampled by hclk; host steps of 7 or more cycles
// Notes: slot and byte counters restart at every start condition
module irs_link_properties (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic scl,
   input wire logic host_sda_o,
   input wire logic host_sda_oe_n,
   input wire logic dev_sda_o,
   input wire logic dev_sda_oe_n,
   input wire logic sda
);
   timeunit 1ns;
   timeprecision 1ps;
   logic scl_q, sda_q, rd_q, acked_q, nak_q;
   logic [3:0] slot_q;
   logic [1:0] byte_q;
   wire logic rise = scl && !scl_q;
   wire logic start_ev = scl && scl_q && sda_q && !sda;
   wire logic stop_ev = scl && scl_q && !sda_q && sda;

   // Slot, byte, direction and acknowledge tracking
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         scl_q <= 1'b1;
         sda_q <= 1'b1;
         rd_q <= 1'b0;
         acked_q <= 1'b0;
         nak_q <= 1'b0;
         slot_q <= 4'h0;
         byte_q <= 2'h0;
      end else begin
         scl_q <= scl;
         sda_q <= sda;
         if (start_ev) begin
            slot_q <= 4'h0;
            byte_q <= 2'h0;
            nak_q <= 1'b0;
            acked_q <= 1'b0;
         end else if (stop_ev) begin
            nak_q <= 1'b0;
         end else if (rise && slot_q == 4'h8) begin
            slot_q <= 4'h0;
            if (byte_q != 2'h3) byte_q <= byte_q + 2'h1;
            if (byte_q == 2'h0) acked_q <= !sda;
            else if (rd_q && sda) nak_q <= 1'b1;
         end else if (rise) begin
            slot_q <= slot_q + 4'h1;
            if (byte_q == 2'h0 && slot_q == 4'h7) rd_q <= sda;
         end
      end
   end

   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);

   dev_open_drain_a: assert property (!dev_sda_oe_n |-> !dev_sda_o)
      else $error("device drives data line high");
   host_open_drain_a: assert property (!host_sda_oe_n |-> !host_sda_o)
      else $error("host drives data line high");
   host_change_a: assert property ($changed(host_sda_oe_n) && scl |-> start_ev || stop_ev)
      else $error("host changed data line while clock high");
   dev_change_low_a: assert property ($changed(dev_sda_oe_n) |-> !scl)
      else $error("device changed data line while clock high");
   stop_release_a: assert property (stop_ev |-> dev_sda_oe_n [*8])
      else $error("device pulls data line after stop");
   addr_quiet_a: assert property (rise && byte_q == 2'h0 && slot_q != 4'h8 |-> dev_sda_oe_n)
      else $error("device pulls during address bits");
   write_ack_a: assert property (rise && slot_q == 4'h8 && byte_q != 2'h0 && acked_q && !rd_q
      |-> !dev_sda_oe_n [*4]) else $error("device missed write acknowledge");
   read_slot9_a: assert property (rise && slot_q == 4'h8 && byte_q != 2'h0 && rd_q
      |-> dev_sda_oe_n) else $error("device pulls in read acknowledge slot");
   nak_silence_a: assert property (rise && nak_q |-> dev_sda_oe_n)
      else $error("device drives after not-acknowledge");
   host_release_a: assert property (rise && rd_q && acked_q && byte_q != 2'h0 &&
      slot_q != 4'h8 && !nak_q |-> host_sda_oe_n) else $error("host pulls during read data");
   nak_seen_c: cover property (rise && nak_q);
endmodule

// ---- testbench/tb.sv ----
// Purpose: drive host end over AHB-Lite and check device end across the link
// Assumes: zero-wait AHB slave; divider set to 6 (7-cycle steps) after the register test
// Notes: expected bytes follow the index map and the skip list
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   import irs_pkg::*;
   logic hclk = 1'b0;
   logic hresetn = 1'b0;
   logic hsel = 1'b0;
   logic hwrite = 1'b0;
   logic ad_pin = 1'b0;
   logic strap_pin = 1'b0;
   logic scl_m = 1'b1;
   logic [1:0] htrans = 2'h0;
   logic [31:0] haddr = 32'h0;
   logic [31:0] hwdata = 32'h0;
   logic [7:0] dev_addr = 8'h54;
   logic [8:0] wire_sr = 9'h0;
   logic hreadyout, hresp, coef_commit, busy;
   logic [31:0] hrdata;
   logic [7:0] access_select;
   int fail_count = 0;
   int samples_checked = 0;
   int commit_cnt = 0;
   irs_link_if link_bus();
   irs_host_end u_irs_host_end (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .link(link_bus));
   irs_dev_end u_irs_dev_end (.hclk(hclk), .hresetn(hresetn), .link(link_bus), .ad_pin(ad_pin),
      .strap_pin(strap_pin), .access_select(access_select), .coef_commit(coef_commit),
      .busy(busy));
   irs_link_properties u_irs_link_properties (.hclk(hclk), .hresetn(hresetn),
      .scl(link_bus.scl), .host_sda_o(link_bus.host_sda_o),
      .host_sda_oe_n(link_bus.host_sda_oe_n), .dev_sda_o(link_bus.dev_sda_o),
      .dev_sda_oe_n(link_bus.dev_sda_oe_n), .sda(link_bus.sda));

   always #2 hclk = ~hclk;
   // Wire bits seen at each clock rise, and commit pulses
   always @(posedge hclk) begin
      scl_m <= link_bus.scl;
      if (link_bus.scl && !scl_m) wire_sr <= {wire_sr[7:0], link_bus.sda};
      if (coef_commit === 1'b1) commit_cnt <= commit_cnt + 1;
   end

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         fail_count++;
         $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic complete_run();
      $display("checks=%0d mismatches=%0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask

   task automatic ahb(input logic [7:0] a, input logic w, input logic [31:0] wd,
      output logic [31:0] rd);
      haddr <= {24'h0, a};
      hwrite <= w;
      htrans <= 2'h2;
      hsel <= 1'b1;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hwdata <= wd;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask

   task automatic xfer(input logic s, p, r, n, input logic [7:0] b, output logic [31:0] st);
      logic [31:0] w;
      logic [31:0] d;
      int k;
      w = 32'h0;
      w[IRS_CMD_START] = s;
      w[IRS_CMD_STOP] = p;
      w[IRS_CMD_READ] = r;
      w[IRS_CMD_NAK] = n;
      w[IRS_CMD_NOBYTE] = n & ~r;
      w[IRS_CMD_TX_LSB +: 8] = b;
      ahb(IRS_CMD_OFS, 1'b1, w, d);
      repeat (2) @(posedge hclk);
      k = 0;
      do begin
         ahb(IRS_STAT_OFS, 1'b0, 32'h0, st);
         k++;
      end while (st[0] !== 1'b0 && k < 1000);
      if (k >= 1000) check(st[0], 32'h0);
   endtask

   task automatic wr(input logic [7:0] idx, input logic [7:0] d[$]);
      logic [31:0] st;
      xfer(1'b1, 1'b0, 1'b0, 1'b0, dev_addr, st);
      check(wire_sr, {dev_addr, 1'b0});
      xfer(1'b0, d.size() == 0, 1'b0, 1'b0, idx, st);
      check(st[1], 32'h1);
      foreach (d[i]) begin
         xfer(1'b0, i == d.size() - 1, 1'b0, 1'b0, d[i], st);
         check(st[1], 32'h1);
      end
   endtask

   task automatic rdc(input logic [7:0] idx, input logic [7:0] e[$]);
      logic [31:0] st;
      int n;
      n = e.size();
      xfer(1'b1, 1'b0, 1'b0, 1'b0, dev_addr, st);
      xfer(1'b0, 1'b0, 1'b0, 1'b0, idx, st);
      check(st[1], 32'h1);
      xfer(1'b1, 1'b0, 1'b0, 1'b0, dev_addr | 8'h01, st);
      check(st[1], 32'h1);
      for (int i = 0; i < n; i++) begin
         xfer(1'b0, i == n - 1, 1'b1, i == n - 1, 8'h00, st);
         check(st[15:8], e[i]);
      end
      repeat (4) @(posedge hclk);
      check(busy, 32'h0);
   endtask

   task automatic do_reset(input logic a, input logic s);
      ad_pin <= a;
      strap_pin <= s;
      hresetn <= 1'b0;
      repeat (5) @(posedge hclk);
      hresetn <= 1'b1;
      repeat (5) @(posedge hclk);
   endtask

   task automatic t_addr();
      logic [7:0] tbl[4] = '{8'h54, 8'h58, 8'h56, 8'h5A};
      logic [31:0] st;
      for (int k = 0; k < 4; k++) begin
         do_reset(k[1], k[0]);
         for (int j = 0; j < 4; j++) begin
            xfer(1'b1, 1'b1, 1'b0, 1'b0, tbl[j], st);
            check(st[1], j == k);
         end
      end
      do_reset(1'b0, 1'b0);
   endtask

   task automatic t_regs();
      logic [31:0] d;
      check(access_select, 32'h0);
      check(busy, 32'h0);
      check({link_bus.scl, link_bus.sda}, 32'h3);
      ahb(IRS_DIV_OFS, 1'b0, 32'h0, d);
      check(d, 32'h8);
      ahb(8'h0C, 1'b1, 32'h5, d);
      ahb(8'h0C, 1'b0, 32'h0, d);
      check(d, 32'h0);
      ahb(IRS_DIV_OFS, 1'b1, 32'h6, d);
      ahb(IRS_DIV_OFS, 1'b0, 32'h0, d);
      check(d, 32'h6);
      check(hresp, 32'h0);
      check(hreadyout, 32'h1);
   endtask

   task automatic t_select();
      logic [7:0] v[5] = '{8'h01, 8'h02, 8'h03, 8'h08, 8'h00};
      foreach (v[i]) begin
         wr(8'h7E, {v[i]});
         check(access_select, v[i]);
      end
      wr(8'h10, {8'h11, 8'h11, 8'h22, 8'h7E, 8'h08});
      check(access_select, 32'h8);
      wr(8'h7E, {8'h00});
      rdc(8'h10, {8'h11});
      rdc(8'h11, {8'h22});
   endtask

   task automatic t_step();
      wr(8'hBA, {8'hA1, 8'hA2});
      wr(8'hCE, {8'hB1, 8'hB2});
      wr(8'hDD, {8'hC1, 8'hC2});
      rdc(8'hBA, {8'hA1, 8'hA2});
      rdc(8'hCE, {8'hB1, 8'hB2});
      rdc(8'hDD, {8'hC1, 8'hC2});
      rdc(8'h3B, {8'h00});
      rdc(8'h4F, {8'h00});
      rdc(8'h5E, {8'h00});
   endtask

   task automatic t_coef();
      logic [7:0] d[$];
      logic [31:0] st;
      int c0;
      wr(8'h7E, {8'h01});
      for (int w = 0; w < 4; w++) begin
         for (int j = 0; j < 4; j++) begin
            d.push_back(8'(w * 16 + j));
         end
      end
      c0 = commit_cnt;
      wr(8'h80, d);
      check(commit_cnt - c0, 32'h0);
      wr(8'h04, {8'h40, 8'h41, 8'h42, 8'h43});
      check(commit_cnt - c0, 32'h1);
      rdc(8'h02, {8'h20, 8'h21, 8'h22, 8'h23});
      xfer(1'b1, 1'b0, 1'b0, 1'b0, dev_addr, st);
      xfer(1'b0, 1'b0, 1'b0, 1'b0, 8'h0A, st);
      xfer(1'b0, 1'b0, 1'b0, 1'b0, 8'h77, st);
      xfer(1'b0, 1'b0, 1'b0, 1'b0, 8'h77, st);
      xfer(1'b0, 1'b1, 1'b0, 1'b1, 8'h00, st);
      rdc(8'h0A, {8'h00, 8'h00, 8'h00, 8'h00});
   endtask

   task automatic t_both();
      wr(8'h7E, {8'h03});
      wr(8'h0A, {8'hDE, 8'hAD, 8'hBE, 8'hEF});
      wr(8'h7E, {8'h02});
      rdc(8'h0A, {8'hDE, 8'hAD, 8'hBE, 8'hEF});
      wr(8'h7E, {8'h01});
      rdc(8'h0A, {8'hDE, 8'hAD, 8'hBE, 8'hEF});
      wr(8'h7E, {8'h00});
      check(access_select, 32'h0);
   endtask

   initial begin
      repeat (5) @(posedge hclk);
      hresetn <= 1'b1;
      repeat (5) @(posedge hclk);
      t_addr();
      t_regs();
      t_select();
      t_step();
      t_coef();
      t_both();
      complete_run();
   end

   initial begin
      #360000;
      fail_count++;
      complete_run();
   end
endmodule
